// ---- alc_consts.svh ----
`ifndef ALC_CONSTS_SVH
`define ALC_CONSTS_SVH

// Register byte offsets
`define ADDR_CTRL      8'h00
`define ADDR_UPPER     8'h04
`define ADDR_LOWER     8'h08
`define ADDR_SET_DLY   8'h0C
`define ADDR_RES_DLY   8'h10
`define ADDR_ROUTE     8'h14
`define ADDR_STATUS    8'h18
`define ADDR_TIMER     8'h1C
`define ADDR_VALUE     8'h20

// Control and route field positions
`define CTRL_SEL_LSB   0
`define CTRL_SEL_MSB   4
`define CTRL_TYPE_BIT  8
`define CTRL_POL_BIT   9
`define ROUTE_DIG_BIT  0
`define ROUTE_REL_BIT  1

// Input selector codes
`define SEL_PROCESS    5'h00
`define SEL_ELECTRICAL_POWER   5'h02
`define SEL_REACTIVE   5'h03
`define SEL_CURRENT    5'h05
`define SEL_OUT_VOLT   5'h06
`define SEL_FREQ       5'h07
`define SEL_DC_VOLT    5'h08
`define SEL_SW_TEMP    5'h09
`define SEL_TEMP1      5'h0A
`define SEL_TEMP3      5'h0C
`define SEL_ENERGY     5'h0D
`define SEL_RUN_TIME   5'h0E
`define SEL_MAINS_TIME 5'h0F
`define SEL_AN_IN1     5'h10
`define SEL_AN_IN4     5'h13
`define SEL_PROC_REF   5'h14
`define SEL_PROC_ERR   5'h15
`define SEL_TEMP4      5'h16
`define SEL_TEMP6      5'h18
`define SEL_MUX1       5'h19
`define SEL_MUX2       5'h1A
`define SEL_COUNT      27

// Range limits, in the selected unit scaled by its decimals
`define MAX_OUT_VOLT   32'sd10000
`define MAX_FREQ       32'sd4000
`define MAX_DC_VOLT    32'sd12500
`define MAX_SW_TEMP    32'sd1000
`define MAX_TEMP       32'sd3000
`define MIN_TEMP       -32'sd1000
`define MAX_ENERGY     32'sd1000000
`define MAX_HOURS      32'sd65535
`define MAX_PERCENT    32'sd100

// Reset values and delay limit
`define UPPER_RST      32'sd300
`define LOWER_RST      32'sd200
`define SEL_RST        5'h05
`define DLY_MAX_S      16'd36000

// Timing
`define CLK_PERIOD_NS  100
`define ONE_SECOND_NS  1000000000

`endif

// ---- alc_pkg.sv ----
package alc_pkg;
  `include "alc_consts.svh"

  typedef logic signed [31:0] value_t;
  typedef value_t [`SEL_COUNT-1:0] meas_array_t;

  typedef enum logic {
    HYSTERESIS = 1'b0,
    WINDOW     = 1'b1
  } mode_t;

  typedef struct packed {
    logic [4:0] sel;
    mode_t      mode;
    logic       pol;
  } cfg_t;

  typedef struct packed {
    value_t current_max;
    value_t power_max;
    value_t reactive_max;
    value_t process_max;
    value_t process_min;
  } rated_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic        out;
    logic [15:0] cnt;
  } dly_state_t;

  typedef struct packed {
    cfg_t        cfg;
    value_t      upper;
    value_t      lower;
    logic [15:0] set_dly;
    logic [15:0] res_dly;
    logic [1:0]  route;
    logic        raw;
    logic [23:0] tick_cnt;
    logic        tick;
    logic [31:0] rdata;
    logic        link_src;
    logic        dig;
    logic        relay;
  } top_state_t;
endpackage

// ---- output_delay.sv ----
`timescale 1ns/1ps
module output_delay (
  input  wire logic        clk,     // System clock
  input  wire logic        rst_n,   // Synchronous reset
  input  wire logic        tick,    // One-second enable
  input  wire logic        raw,     // Undelayed comparator result
  input  wire logic [15:0] set_dly, // Assert delay, seconds
  input  wire logic [15:0] res_dly, // Release delay, seconds
  output logic             out,     // Delayed result
  output logic [15:0]      timer    // Elapsed seconds
);
  import alc_pkg::*;

  dly_state_t s_q;
  dly_state_t s_d;
  logic [15:0] dly;

  always_comb begin
    s_d = s_q;
    dly = raw ? set_dly : res_dly;
    if (raw == s_q.out) begin
      s_d.cnt = 16'h0000;
    end else if (dly == 16'h0000) begin
      s_d.out = raw;
    end else if (tick) begin
      if (s_q.cnt + 16'h0001 >= dly) begin
        s_d.out = raw;
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{out: 1'b0, cnt: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign out   = s_q.out;
  assign timer = s_q.cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  zero_delay_a: assert property (
    (raw != out && dly == 16'h0000) |=> out == $past(raw))
    else $error("zero delay not immediate");
  hold_delay_a: assert property (
    (raw != out && dly != 16'h0000 && !tick) |=> out == $past(out))
    else $error("output moved without a tick");
endmodule

// ---- level_comparator_one.sv ----
`timescale 1ns/1ps
`include "alc_consts.svh"
module level_comparator_one #(
  parameter int unsigned TICK_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
  input  wire logic                clk,             // 10 MHz clock
  input  wire logic                rst_n,           // Synchronous reset
  input  wire alc_pkg::bus_req_t   bus,             // Register request
  output logic              [31:0] rdata,           // Read data
  input  wire alc_pkg::meas_array_t meas,           // Measured values
  input  wire alc_pkg::rated_t     rated,           // Rated maxima
  output logic                     virtual_link_source, // Link feed
  output logic                     digital_out,     // Digital output
  output logic                     relay_out        // Relay output
);
  import alc_pkg::*;

  localparam top_state_t S_RST = '{
    cfg:      '{sel: `SEL_RST, mode: HYSTERESIS, pol: 1'b0},
    upper:    `UPPER_RST,
    lower:    `LOWER_RST,
    set_dly:  16'h0000,
    res_dly:  16'h0000,
    route:    2'b00,
    raw:      1'b0,
    tick_cnt: 24'h000000,
    tick:     1'b0,
    rdata:    32'h00000000,
    link_src: 1'b0,
    dig:      1'b0,
    relay:    1'b0
  };
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  top_state_t  s_q;
  top_state_t  s_d;
  value_t      sel_val;
  value_t      cmp_val;
  value_t      rmax;
  value_t      rmin;
  logic        sel_ok;
  logic        in_band;
  logic        delayed;
  logic [15:0] timer;

  // True when a selector code is below SEL_COUNT and is not one of the unused codes 1 or 4
  function automatic logic code_valid(input logic [4:0] c);
    code_valid = (c < 5'(`SEL_COUNT)) && c != 5'h01 && c != 5'h04;
  endfunction

  // Largest threshold allowed for a selection
  function automatic value_t range_max(input logic [4:0] c,
                                       input rated_t r);
    value_t m;
    m = 32'sd0;
    if (c == `SEL_PROCESS || c == `SEL_PROC_REF || c == `SEL_PROC_ERR) begin
      m = r.process_max;
    end else if (c == `SEL_ELECTRICAL_POWER) begin
      m = r.power_max;
    end else if (c == `SEL_REACTIVE) begin
      m = r.reactive_max;
    end else if (c == `SEL_CURRENT) begin
      m = r.current_max;
    end else if (c == `SEL_OUT_VOLT) begin
      m = `MAX_OUT_VOLT;
    end else if (c == `SEL_FREQ) begin
      m = `MAX_FREQ;
    end else if (c == `SEL_DC_VOLT) begin
      m = `MAX_DC_VOLT;
    end else if (c == `SEL_SW_TEMP) begin
      m = `MAX_SW_TEMP;
    end else if ((c >= `SEL_TEMP1 && c <= `SEL_TEMP3) ||
                 (c >= `SEL_TEMP4 && c <= `SEL_TEMP6)) begin
      m = `MAX_TEMP;
    end else if (c == `SEL_ENERGY) begin
      m = `MAX_ENERGY;
    end else if (c == `SEL_RUN_TIME || c == `SEL_MAINS_TIME) begin
      m = `MAX_HOURS;
    end else if ((c >= `SEL_AN_IN1 && c <= `SEL_AN_IN4) ||
                 c == `SEL_MUX1 || c == `SEL_MUX2) begin
      m = `MAX_PERCENT;
    end
    range_max = m;
  endfunction

  // Smallest threshold allowed for a selection
  function automatic value_t range_min(input logic [4:0] c,
                                       input logic pol,
                                       input rated_t r);
    value_t m;
    m = 32'sd0;
    if (pol) begin
      m = -range_max(c, r);
    end else if ((c >= `SEL_TEMP1 && c <= `SEL_TEMP3) ||
                 (c >= `SEL_TEMP4 && c <= `SEL_TEMP6)) begin
      m = `MIN_TEMP;
    end else if (c == `SEL_PROCESS || c == `SEL_PROC_REF ||
                 c == `SEL_PROC_ERR) begin
      m = r.process_min;
    end
    range_min = m;
  endfunction

  function automatic value_t clamp(input value_t v, input value_t lo,
                                   input value_t hi);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  function automatic logic [15:0] dly_lim(input logic [31:0] w);
    dly_lim = (w[31:16] != 16'h0000 || w[15:0] > `DLY_MAX_S) ?
              `DLY_MAX_S : w[15:0];
  endfunction

  always_comb begin
    sel_ok  = code_valid(s_q.cfg.sel);
    sel_val = sel_ok ? meas[s_q.cfg.sel] : 32'sd0;
    cmp_val = (s_q.cfg.pol || sel_val >= 0) ? sel_val : -sel_val;
    rmax    = range_max(s_q.cfg.sel, rated);
    rmin    = range_min(s_q.cfg.sel, s_q.cfg.pol, rated);
    in_band = cmp_val >= s_q.lower && cmp_val <= s_q.upper;
  end

  always_comb begin
    s_d = s_q;

    // One-second enable
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = 24'h000000;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 24'h000001;
    end

    // Comparator core
    unique case (s_q.cfg.mode)
      HYSTERESIS: begin
        if (cmp_val > s_q.upper) begin
          s_d.raw = 1'b1;
        end else if (cmp_val < s_q.lower &&
                     s_q.lower <= s_q.upper) begin
          s_d.raw = 1'b0;
        end
      end
      WINDOW: begin
        s_d.raw = in_band;
      end
    endcase

    // Delayed result to each destination
    s_d.link_src = delayed;
    s_d.dig      = delayed & s_q.route[`ROUTE_DIG_BIT];
    s_d.relay    = delayed & s_q.route[`ROUTE_REL_BIT];

    // Register writes; thresholds are clamped only here, so a later
    // selection change leaves an out-of-range threshold in place
    if (bus.wr) begin
      unique case (bus.addr)
        `ADDR_CTRL: begin
          s_d.cfg.sel  = bus.wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
          s_d.cfg.mode = mode_t'(bus.wdata[`CTRL_TYPE_BIT]);
          s_d.cfg.pol  = bus.wdata[`CTRL_POL_BIT];
        end
        `ADDR_UPPER: s_d.upper = clamp(bus.wdata, rmin, rmax);
        `ADDR_LOWER: s_d.lower = clamp(bus.wdata, rmin, rmax);
        `ADDR_SET_DLY: s_d.set_dly = dly_lim(bus.wdata);
        `ADDR_RES_DLY: s_d.res_dly = dly_lim(bus.wdata);
        `ADDR_ROUTE: s_d.route = bus.wdata[1:0];
        default: ;
      endcase
    end

    // Register reads, data valid in the next cycle only
    s_d.rdata = 32'h00000000;
    if (bus.rd) begin
      unique case (bus.addr)
        `ADDR_CTRL: s_d.rdata = {22'h000000, s_q.cfg.pol, s_q.cfg.mode,
                                 3'h0, s_q.cfg.sel};
        `ADDR_UPPER:   s_d.rdata = s_q.upper;
        `ADDR_LOWER:   s_d.rdata = s_q.lower;
        `ADDR_SET_DLY: s_d.rdata = {16'h0000, s_q.set_dly};
        `ADDR_RES_DLY: s_d.rdata = {16'h0000, s_q.res_dly};
        `ADDR_ROUTE:   s_d.rdata = {30'h00000000, s_q.route};
        `ADDR_STATUS:  s_d.rdata = {29'h00000000, !sel_ok, s_q.raw,
                                    delayed};
        `ADDR_TIMER:   s_d.rdata = {16'h0000, timer};
        `ADDR_VALUE:   s_d.rdata = cmp_val;
        default:       s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  output_delay u_delay (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (s_q.tick),
    .raw     (s_q.raw),
    .set_dly (s_q.set_dly),
    .res_dly (s_q.res_dly),
    .out     (delayed),
    .timer   (timer)
  );

  assign rdata               = s_q.rdata;
  assign virtual_link_source = s_q.link_src;
  assign digital_out         = s_q.dig;
  assign relay_out           = s_q.relay;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire hyst = s_q.cfg.mode == HYSTERESIS;
  wire win  = s_q.cfg.mode == WINDOW;

  sequence above_upper_s;
    hyst && cmp_val > s_q.upper;
  endsequence
  sequence below_lower_s;
    hyst && cmp_val < s_q.lower && s_q.lower <= s_q.upper;
  endsequence
  sequence write_s(logic [7:0] a);
    bus.wr && bus.addr == a;
  endsequence
  sequence read_s(logic [7:0] a);
    bus.rd && bus.addr == a;
  endsequence

  hyst_set_a: assert property (above_upper_s |=> s_q.raw)
    else $error("hysteresis did not set above upper");
  hyst_hold_a: assert property (
    (hyst && s_q.raw && cmp_val >= s_q.lower) |=> s_q.raw)
    else $error("hysteresis cleared above lower");
  hyst_clear_a: assert property (
    (below_lower_s and !(cmp_val > s_q.upper)) |=> !s_q.raw)
    else $error("hysteresis did not clear below lower");
  rising_hold_a: assert property (
    (hyst && !s_q.raw && cmp_val <= s_q.upper) |=> !s_q.raw)
    else $error("hysteresis set below upper");
  window_band_a: assert property (
    win |=> s_q.raw == $past(in_band))
    else $error("window output wrong");
  latch_hold_a: assert property (
    (hyst && s_q.raw && s_q.lower > s_q.upper) |=> s_q.raw)
    else $error("latched output released");
  magnitude_a: assert property (
    !s_q.cfg.pol |-> (cmp_val >= 0 &&
    (cmp_val == sel_val || cmp_val == -sel_val)))
    else $error("unsigned value not magnitude");
  signed_val_a: assert property (s_q.cfg.pol |-> cmp_val == sel_val)
    else $error("signed value altered");
  decode_curr_a: assert property (
    s_q.cfg.sel == `SEL_CURRENT |-> sel_val == meas[5])
    else $error("current code decoded wrong");
  decode_mux_a: assert property (
    s_q.cfg.sel == `SEL_MUX2 |-> sel_val == meas[26])
    else $error("mux code decoded wrong");
  upper_range_a: assert property (
    write_s(`ADDR_UPPER) ##0 !$past(bus.wr) |=> s_q.upper <= $past(rmax))
    else $error("upper threshold above range");
  signed_min_a: assert property (
    (write_s(`ADDR_LOWER) and s_q.cfg.pol) |=>
    s_q.lower >= -$past(rmax))
    else $error("lower below signed minimum");
  upper_rst_a: assert property (
    $rose(rst_n) |-> s_q.upper == `UPPER_RST &&
    s_q.cfg.sel == `SEL_CURRENT && !s_q.cfg.pol)
    else $error("reset defaults wrong");
  route_a: assert property (
    ##1 (virtual_link_source == $past(delayed) &&
    relay_out == ($past(delayed) && $past(s_q.route[1]))))
    else $error("routing of output wrong");
  dig_route_a: assert property (
    ##1 (digital_out == ($past(delayed) && $past(s_q.route[0]))))
    else $error("digital routing wrong");

  // Decode, register and one-second enable checks
  invalid_zero_a: assert property (
    !sel_ok |-> sel_val == 32'sd0)
    else $error("unused code not zero");
  decode_proc_a: assert property (
    s_q.cfg.sel == `SEL_PROCESS |-> sel_val == meas[0])
    else $error("process code decoded wrong");
  decode_an_a: assert property (
    s_q.cfg.sel == `SEL_AN_IN1 |-> sel_val == meas[16])
    else $error("analogue code decoded wrong");
  lower_range_a: assert property (
    write_s(`ADDR_LOWER) |=>
    s_q.lower >= $past(rmin) && s_q.lower <= $past(rmax))
    else $error("lower threshold out of range");
  upper_min_a: assert property (
    write_s(`ADDR_UPPER) |=> s_q.upper >= $past(rmin))
    else $error("upper threshold below range");
  sel_write_a: assert property (
    write_s(`ADDR_CTRL) |=>
    s_q.cfg.sel == $past(bus.wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB]))
    else $error("selector write lost");
  mode_write_a: assert property (
    write_s(`ADDR_CTRL) |=>
    s_q.cfg.mode == $past(bus.wdata[`CTRL_TYPE_BIT]))
    else $error("type write lost");
  pol_write_a: assert property (
    write_s(`ADDR_CTRL) |=>
    s_q.cfg.pol == $past(bus.wdata[`CTRL_POL_BIT]))
    else $error("polarity write lost");
  tick_pulse_a: assert property (
    s_q.tick |=> !s_q.tick)
    else $error("second enable longer than one cycle");
  tick_wrap_a: assert property (
    s_q.tick |-> s_q.tick_cnt == 24'h000000)
    else $error("second enable off its count");
  set_clamp_a: assert property (
    write_s(`ADDR_SET_DLY) |=> s_q.set_dly <= `DLY_MAX_S)
    else $error("assert delay above limit");
  res_clamp_a: assert property (
    write_s(`ADDR_RES_DLY) |=> s_q.res_dly <= `DLY_MAX_S)
    else $error("release delay above limit");
  value_read_a: assert property (
    read_s(`ADDR_VALUE) |=> rdata == $past(cmp_val))
    else $error("compared value read wrong");
  status_read_a: assert property (
    read_s(`ADDR_STATUS) |=> rdata[2] == !$past(sel_ok))
    else $error("invalid selector flag wrong");
endmodule

// ---- tb_level_comparator_one.sv ----
`timescale 1ns/1ps
`include "alc_consts.svh"
module tb_level_comparator_one;
  import alc_pkg::*;
  logic        clk;
  logic        rst_n;
  bus_req_t    bus;
  logic [31:0] rdata;
  meas_array_t meas;
  rated_t      rated;
  logic        vls;
  logic        dig;
  logic        rel;
  logic [1:0]  route;
  logic [31:0] rd_v;
  int          fails;
  int          comparisons;

  level_comparator_one #(.TICK_CYCLES(4)) u_dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .bus                 (bus),
    .rdata               (rdata),
    .meas                (meas),
    .rated               (rated),
    .virtual_link_source (vls),
    .digital_out         (dig),
    .relay_out           (rel)
  );

  always #50 clk = ~clk;

  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_out(string n, logic e);
    comparisons++;
    if (vls !== e || dig !== (e & route[0]) || rel !== (e & route[1])) begin
      fails++;
      $display("Error %s expected %b seen %b%b%b", n, e, vls, dig, rel);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    rd_v = rdata;
  endtask

  task automatic set_meas(int code, logic [31:0] v);
    @(posedge clk);
    meas[code] <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Returns edges until the link output reaches e; a hang ends the run
  task automatic wait_out(logic e, output int n);
    for (n = 1; n < 60; n++) begin
      @(posedge clk);
      #1;
      if (vls === e) break;
    end
    if (n == 60) begin
      fails++;
      $display("Error wait_out expected %b seen %b", e, vls);
      finish_test();
    end
  endtask

  task automatic t_reset;
    chk_out("out_rst", 1'b0);
    rd_reg(`ADDR_CTRL);
    chk32("ctrl_rst", 32'h0000_0005, rd_v);
    rd_reg(`ADDR_UPPER);
    chk32("upper_rst", 32'h0000_012C, rd_v);
    rd_reg(`ADDR_SET_DLY);
    chk32("set_dly_rst", 32'h0, rd_v);
    rd_reg(`ADDR_RES_DLY);
    chk32("res_dly_rst", 32'h0, rd_v);
    $display("test reset done");
  endtask

  task automatic t_hyst;
    wr_reg(`ADDR_ROUTE, 32'h3);
    route = 2'h3;
    set_meas(5, 32'd250);
    chk_out("hyst_mid_up", 1'b0);
    set_meas(5, 32'd301);
    chk_out("hyst_above", 1'b1);
    wr_reg(`ADDR_ROUTE, 32'h2);
    route = 2'h2;
    set_meas(5, 32'd250);
    chk_out("hyst_mid_down", 1'b1);
    set_meas(5, 32'd200);
    chk_out("hyst_at_lower", 1'b1);
    set_meas(5, 32'd199);
    chk_out("hyst_below", 1'b0);
    $display("test hysteresis done");
  endtask

  task automatic t_pol;
    set_meas(5, 32'hFFFF_FE70);
    chk_out("abs_high", 1'b1);
    rd_reg(`ADDR_VALUE);
    chk32("abs_value", 32'd400, rd_v);
    wr_reg(`ADDR_CTRL, 32'h0000_0205);
    set_meas(5, 32'hFFFF_FE70);
    chk_out("signed_low", 1'b0);
    wr_reg(`ADDR_CTRL, 32'h0000_0005);
    $display("test polarity done");
  endtask

  task automatic t_window;
    logic [31:0] v [5] = '{32'd250, 32'd350, 32'd300, 32'd199, 32'd200};
    logic        e [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    set_meas(5, 32'd0);
    wr_reg(`ADDR_CTRL, 32'h0000_0105);
    for (int i = 0; i < 5; i++) begin
      set_meas(5, v[i]);
      chk_out("window", e[i]);
    end
    wr_reg(`ADDR_CTRL, 32'h0000_0005);
    $display("test window done");
  endtask

  task automatic t_latch;
    set_meas(5, 32'd0);
    wr_reg(`ADDR_LOWER, 32'd400);
    set_meas(5, 32'd301);
    chk_out("latch_set", 1'b1);
    set_meas(5, 32'd0);
    chk_out("latch_hold", 1'b1);
    wr_reg(`ADDR_LOWER, 32'd200);
    set_meas(5, 32'd0);
    chk_out("latch_freed", 1'b0);
    $display("test latch done");
  endtask

  task automatic t_sel;
    for (int i = 0; i < 27; i++) begin
      meas[i] <= 32'(10 + i);
    end
    for (int i = 0; i < 27; i++) begin
      wr_reg(`ADDR_CTRL, 32'(i));
      repeat (3) @(posedge clk);
      rd_reg(`ADDR_STATUS);
      chk32("sel_status", {29'h0, i == 1 || i == 4, 2'b00}, rd_v);
      if (i != 1 && i != 4) begin
        rd_reg(`ADDR_VALUE);
        chk32("sel_value", 32'(10 + i), rd_v);
      end
    end
    $display("test selector done");
  endtask

  task automatic t_range;
    logic [31:0] c [7] = '{32'h5, 32'h7, 32'hD, 32'hE, 32'h10, 32'h210,
                           32'hA};
    logic [7:0]  a [7] = '{`ADDR_UPPER, `ADDR_UPPER, `ADDR_UPPER,
                           `ADDR_UPPER, `ADDR_LOWER, `ADDR_LOWER,
                           `ADDR_LOWER};
    logic [31:0] w [7] = '{32'd1500, 32'd5000, 32'd2000000, 32'd70000,
                           -32'sd50, -32'sd150, -32'sd2000};
    logic [31:0] e [7] = '{32'd1000, 32'd4000, 32'd1000000, 32'd65535,
                           32'd0, -32'sd100, -32'sd1000};
    for (int i = 0; i < 7; i++) begin
      wr_reg(`ADDR_CTRL, c[i]);
      wr_reg(a[i], w[i]);
      rd_reg(a[i]);
      chk32("range_clamp", e[i], rd_v);
    end
    wr_reg(`ADDR_CTRL, 32'h5);
    wr_reg(`ADDR_UPPER, 32'd300);
    wr_reg(`ADDR_LOWER, 32'd200);
    $display("test range done");
  endtask

  task automatic t_delay;
    int n;
    wr_reg(`ADDR_SET_DLY, 32'd40000);
    rd_reg(`ADDR_SET_DLY);
    chk32("dly_clamp", 32'd36000, rd_v);
    wr_reg(`ADDR_SET_DLY, 32'd3);
    wr_reg(`ADDR_RES_DLY, 32'd2);
    set_meas(5, 32'd0);
    @(posedge clk);
    meas[5] <= 32'd301;
    wait_out(1'b1, n);
    chk32("set_delay", 32'h1, 32'(n >= 9 && n <= 15));
    @(posedge clk);
    meas[5] <= 32'd0;
    wait_out(1'b0, n);
    chk32("res_delay", 32'h1, 32'(n >= 5 && n <= 11));
    @(posedge clk);
    meas[5] <= 32'd301;
    repeat (6) @(posedge clk);
    rd_reg(`ADDR_TIMER);
    chk32("timer", 32'h1, 32'(rd_v >= 32'd1 && rd_v <= 32'd2));
    wait_out(1'b1, n);
    $display("test delay done");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    meas = '0;
    route = 2'h0;
    fails = 0;
    comparisons = 0;
    rated = '{current_max: 32'sd1000, power_max: 32'sd1000,
              reactive_max: 32'sd1000, process_max: 32'sd1000,
              process_min: -32'sd1000};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_hyst();
    t_pol();
    t_window();
    t_latch();
    t_sel();
    t_range();
    t_delay();
    finish_test();
  end
endmodule
